// file: src/pscc_cfg.svh
// Constants of the power-save and clock-rate controller.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef PSCC_CFG_SVH
`define PSCC_CFG_SVH
`define PSCC_IDLE_BIT 0
`define PSCC_PDWN_BIT 1
`define PSCC_POWER_CONTROL_REGISTER_RST 8'h00
`define PSCC_REG_POWER_CONTROL_REGISTER 2'h0
`define PSCC_REG_FSTAT 2'h1
`define PSCC_REG_CLKCFG 2'h2
`define PSCC_EDC_BIT 0
`define PSCC_CYC_X1 4'hC
`define PSCC_CYC_X2 4'h6
`define PSCC_WAKE_CLKS 1024
`endif

// file: src/pscc_pkg.sv
// Types of the power-save and clock-rate controller.
// Assumes pscc_cfg.svh is on the include path.
`include "pscc_cfg.svh"
package pscc_pkg;
  typedef enum logic [1:0] {
    RUN,
    IDLE,
    PDWN,
    WAKE
  } pscc_mode_e;
  typedef struct packed {
    logic ale;
    logic program_store_strobe_n_n;
  } pscc_strobe_s;
endpackage

// file: src/pscc_ctrl.sv
// Power-save mode sequencer and machine-cycle generator.
// Assumes a core that reports interrupt service starts and stalls on run_enable.
//
// Overview of operation
// [R1] Writing idle bit enters idle.
// [R2] Idle halts the core, clock keeps running.
// [R3] Idle keeps RAM and registers unchanged.
// [R4] Interrupt start in idle clears idle bit.
// [R5] Resume after the entering instruction on return.
// [R6] Hardware reset ends any mode fully.
// [R7] Writing power-down bit enters power-down.
// [R8] Power-down gates clock; only level interrupts wake.
// [R9] Power-down keeps RAM and registers.
// [R10] Only level interrupt or reset leaves power-down.
// [R11] Low interrupt pin restarts the oscillator.
// [R12] Host holds pin low 1024 clocks.
// [R13] Pin high again starts service routine.
// [R14] Idle drives both strobes high.
// [R15] Power-down drives both strobes low.
// [R16] Machine cycle is 12 clocks, or 6.
// [R17] Doubling set only by programming commands.
// [R18] Active-low status flag shows doubled mode.
// [R19] Doubling only with internal access selected.
// [R20] Oscillator output stays undoubled.
// [R21] Both bits together choose power-down.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ns
`include "pscc_cfg.svh"
module pscc_ctrl #(
  parameter int WAKE_CLKS = `PSCC_WAKE_CLKS
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // Register port.
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Core handshake.
  input wire logic INT_START,
  input wire logic INT_LEVEL_EN,
  input wire logic PROG_DOUBLE_SET,
  input wire logic PROG_DOUBLE_VAL,
  input wire logic EXT_ACCESS_SEL_N,
  input wire logic EXT_INT_N,
  input wire logic OSC_IN,
  output logic RUN_ENABLE,
  output logic CLK_GATE_EN,
  output logic OSC_RESTART,
  output logic WAKE_VECTOR,
  output logic MCYCLE_STROBE,
  output logic OSC_OUT,
  // Bus strobes.
  output logic ALE,
  output logic PROG_STORE_STROBE_N
);
  initial
  begin
    if (WAKE_CLKS < 1 || WAKE_CLKS > 65535)
    begin
      $error("WAKE_CLKS out of range.");
    end
  end

  pscc_pkg::pscc_mode_e mode_q, mode_d;
  logic [7:0] power_control_register_q, power_control_register_d;
  logic dbl_q, dbl_d;
  logic [15:0] wcnt_q, wcnt_d;
  logic [3:0] mcnt_q, mcnt_d;
  logic [7:0] rdata_d;
  logic run_d, gate_d, osc_d, vec_d, mstb_d, oscout_d;
  pscc_pkg::pscc_strobe_s stb_d, stb_q;

  function automatic logic [3:0] cyc_len(input logic dbl);
    cyc_len = dbl ? `PSCC_CYC_X2 : `PSCC_CYC_X1;
  endfunction

  always_comb
  begin
    mode_d = mode_q;
    power_control_register_d = power_control_register_q;
    dbl_d = dbl_q;
    wcnt_d = wcnt_q;
    vec_d = 1'b0;
    if (WR && ADDR == `PSCC_REG_POWER_CONTROL_REGISTER && mode_q == pscc_pkg::RUN)
    begin
      power_control_register_d = WDATA;
      if (WDATA[`PSCC_PDWN_BIT]) // R7 R21
      begin
        mode_d = pscc_pkg::PDWN;
      end
      else if (WDATA[`PSCC_IDLE_BIT]) // R1
      begin
        mode_d = pscc_pkg::IDLE;
      end
    end
    if (PROG_DOUBLE_SET) // R17
    begin
      dbl_d = PROG_DOUBLE_VAL;
    end
    unique case (mode_q)
      pscc_pkg::RUN:
      begin
      end
      pscc_pkg::IDLE:
      begin
        if (INT_START) // R4
        begin
          power_control_register_d[`PSCC_IDLE_BIT] = 1'b0;
          mode_d = pscc_pkg::RUN;
        end
      end
      pscc_pkg::PDWN:
      begin
        wcnt_d = '0;
        if (!EXT_INT_N && INT_LEVEL_EN) // R10 R11
        begin
          mode_d = pscc_pkg::WAKE;
        end
      end
      pscc_pkg::WAKE:
      begin
        if (wcnt_q != 16'hFFFF)
        begin
          wcnt_d = wcnt_q + 16'h0001;
        end
        if (EXT_INT_N) // R13
        begin
          power_control_register_d[`PSCC_PDWN_BIT] = 1'b0;
          mode_d = pscc_pkg::RUN;
          vec_d = 1'b1;
        end
      end
    endcase
  end

  always_comb
  begin
    rdata_d = 8'h00;
    if (RD)
    begin
      unique case (ADDR)
        `PSCC_REG_POWER_CONTROL_REGISTER: rdata_d = power_control_register_q;
        `PSCC_REG_FSTAT: rdata_d = {7'h00, ~dbl_q}; // R18
        `PSCC_REG_CLKCFG: rdata_d = {6'h00, mode_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    run_d = (mode_d == pscc_pkg::RUN); // R2 R3 R5 R9
    gate_d = (mode_d != pscc_pkg::PDWN); // R8
    osc_d = (mode_d == pscc_pkg::WAKE); // R11
    oscout_d = gate_d ? OSC_IN : 1'b0; // R20
    stb_d = '{ale: 1'b1, program_store_strobe_n_n: 1'b1}; // R14
    if (mode_d == pscc_pkg::PDWN || mode_d == pscc_pkg::WAKE)
    begin
      stb_d = '{ale: 1'b0, program_store_strobe_n_n: 1'b0}; // R15
    end
    mcnt_d = mcnt_q;
    mstb_d = 1'b0;
    if (run_d)
    begin
      if (mcnt_q >= cyc_len(dbl_q && EXT_ACCESS_SEL_N) - 4'h1) // R16 R19
      begin
        mcnt_d = 4'h0;
        mstb_d = 1'b1;
      end
      else
      begin
        mcnt_d = mcnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN) // R6
    begin
      mode_q <= pscc_pkg::RUN;
      power_control_register_q <= `PSCC_POWER_CONTROL_REGISTER_RST;
      dbl_q <= 1'b0;
      wcnt_q <= '0;
      mcnt_q <= 4'h0;
      RDATA <= 8'h00;
      RUN_ENABLE <= 1'b1;
      CLK_GATE_EN <= 1'b1;
      OSC_RESTART <= 1'b0;
      WAKE_VECTOR <= 1'b0;
      MCYCLE_STROBE <= 1'b0;
      OSC_OUT <= 1'b0;
      stb_q <= '{ale: 1'b1, program_store_strobe_n_n: 1'b1};
    end
    else
    begin
      mode_q <= mode_d;
      power_control_register_q <= power_control_register_d;
      dbl_q <= dbl_d;
      wcnt_q <= wcnt_d;
      mcnt_q <= mcnt_d;
      RDATA <= rdata_d;
      RUN_ENABLE <= run_d;
      CLK_GATE_EN <= gate_d;
      OSC_RESTART <= osc_d;
      WAKE_VECTOR <= vec_d;
      MCYCLE_STROBE <= mstb_d;
      OSC_OUT <= oscout_d;
      stb_q <= stb_d;
    end
  end

  assign ALE = stb_q.ale;
  assign PROG_STORE_STROBE_N = stb_q.program_store_strobe_n_n;

  // Checker helper: clocks since the last machine-cycle strobe of an unbroken run.
  logic [4:0] mgap_q, mgap_d;
  logic mvalid_q, mvalid_d;
  logic eff_q, eff_d;

  always_comb
  begin
    eff_d = dbl_q && EXT_ACCESS_SEL_N;
    mgap_d = mgap_q;
    mvalid_d = mvalid_q;
    if (MCYCLE_STROBE)
    begin
      mgap_d = 5'h01;
      mvalid_d = 1'b1;
    end
    else if (RUN_ENABLE && mgap_q != 5'h1F)
    begin
      mgap_d = mgap_q + 5'h01;
    end
    if (!RUN_ENABLE || eff_d != eff_q)
    begin
      mvalid_d = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mgap_q <= 5'h00;
      mvalid_q <= 1'b0;
      eff_q <= 1'b0;
    end
    else
    begin
      mgap_q <= mgap_d;
      mvalid_q <= mvalid_d;
      eff_q <= eff_d;
    end
  end

  a_idle_entry: assert property (@(posedge CLK) disable iff (!RSTN) // R1
    WR && ADDR == `PSCC_REG_POWER_CONTROL_REGISTER && mode_q == pscc_pkg::RUN && WDATA[1:0] == 2'b01
    |=> mode_q == pscc_pkg::IDLE ##1 !RUN_ENABLE)
    else $error("Idle not entered.");
  a_pdwn_prio: assert property (@(posedge CLK) disable iff (!RSTN) // R21
    WR && ADDR == `PSCC_REG_POWER_CONTROL_REGISTER && mode_q == pscc_pkg::RUN && WDATA[1]
    |=> mode_q == pscc_pkg::PDWN)
    else $error("Power-down not chosen.");
  a_idle_exit: assert property (@(posedge CLK) disable iff (!RSTN) // R4
    mode_q == pscc_pkg::IDLE && INT_START |=> !power_control_register_q[0] && mode_q == pscc_pkg::RUN)
    else $error("Idle exit wrong.");
  a_idle_strobes: assert property (@(posedge CLK) disable iff (!RSTN) // R14
    mode_q == pscc_pkg::IDLE |-> ALE && PROG_STORE_STROBE_N)
    else $error("Idle strobes not high.");
  a_pdwn_strobes: assert property (@(posedge CLK) disable iff (!RSTN) // R15
    mode_q == pscc_pkg::PDWN |-> !ALE && !PROG_STORE_STROBE_N && !CLK_GATE_EN)
    else $error("Power-down outputs wrong.");
  a_wake_osc: assert property (@(posedge CLK) disable iff (!RSTN) // R11
    mode_q == pscc_pkg::PDWN && !EXT_INT_N && INT_LEVEL_EN |=> ##1 OSC_RESTART)
    else $error("Oscillator not restarted.");
  a_wake_vec: assert property (@(posedge CLK) disable iff (!RSTN) // R13
    mode_q == pscc_pkg::WAKE && EXT_INT_N |=> WAKE_VECTOR && !power_control_register_q[1])
    else $error("Wake vector missing.");
  a_pdwn_hold: assert property (@(posedge CLK) disable iff (!RSTN) // R10
    mode_q == pscc_pkg::PDWN && (EXT_INT_N || !INT_LEVEL_EN) |=> mode_q == pscc_pkg::PDWN)
    else $error("Power-down left without wake.");
  a_edc_flag: assert property (@(posedge CLK) disable iff (!RSTN) // R18
    RD && ADDR == `PSCC_REG_FSTAT |=> RDATA[0] == !dbl_q)
    else $error("Double flag wrong.");

  a_mcycle_len: assert property (@(posedge CLK) disable iff (!RSTN) // R16 R19
    MCYCLE_STROBE && mvalid_q |-> mgap_q == {1'b0, cyc_len(eff_q)})
    else $error("Machine cycle length wrong.");

  a_run_outputs: assert property (@(posedge CLK) disable iff (!RSTN) // R2
    mode_q == pscc_pkg::RUN |-> RUN_ENABLE && CLK_GATE_EN && ALE && PROG_STORE_STROBE_N)
    else $error("Run outputs wrong.");

  a_idle_clock: assert property (@(posedge CLK) disable iff (!RSTN) // R2
    mode_q == pscc_pkg::IDLE |-> !RUN_ENABLE && CLK_GATE_EN && !MCYCLE_STROBE)
    else $error("Idle clock state wrong.");

  a_wake_outputs: assert property (@(posedge CLK) disable iff (!RSTN) // R11 R15
    mode_q == pscc_pkg::WAKE |-> OSC_RESTART && !ALE && !PROG_STORE_STROBE_N)
    else $error("Wake outputs wrong.");

  a_pdwn_osc: assert property (@(posedge CLK) disable iff (!RSTN) // R8
    mode_q == pscc_pkg::PDWN |-> !OSC_OUT && !RUN_ENABLE)
    else $error("Power-down clock not stopped.");

  a_rdata_quiet: assert property (@(posedge CLK) disable iff (!RSTN) // R3
    !RD |=> RDATA == 8'h00)
    else $error("Read data outside read cycle.");

  a_dbl_load: assert property (@(posedge CLK) disable iff (!RSTN) // R17
    PROG_DOUBLE_SET |=> dbl_q == $past(PROG_DOUBLE_VAL))
    else $error("Doubling not loaded.");

  a_dbl_keep: assert property (@(posedge CLK) disable iff (!RSTN) // R17
    !PROG_DOUBLE_SET |=> $stable(dbl_q))
    else $error("Doubling changed without command.");
endmodule

// file: verification/pscc_far_model.sv
// Core and external interrupt pin model facing the controller.
// Assumes the bench pulses go_irq or go_pin for one cycle.
`timescale 1ns/1ns
module pscc_far_model #(
  parameter int HOLD = 1024
) (
  input wire logic clk,
  input wire logic go_irq,
  input wire logic go_pin,
  output logic int_start,
  output logic ext_int_n
);
  int cnt = 0;
  initial int_start = 1'b0;
  always @(posedge clk)
  begin
    int_start <= go_irq;
    cnt <= go_pin ? HOLD : (cnt > 0 ? cnt - 1 : 0);
  end
  assign ext_int_n = (cnt == 0);
endmodule

// file: verification/test_power_save_clock_ctrl.sv
// Self-checking bench of the power-save controller against a reference model.
// Assumes the design files and pscc_far_model are compiled first.
`timescale 1ns/1ns
module test_power_save_clock_ctrl;
  localparam int HC = 1024;
  logic CLK = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic lvl = 1'b0;
  logic pset = 1'b0;
  logic pval = 1'b0;
  logic easn = 1'b1;
  logic osc = 1'b0;
  logic girq = 1'b0;
  logic gpin = 1'b0;
  logic ck = 1'b0;
  logic [7:0] rdata;
  logic run, gate, rosc, wvec, mcyc, oscout, ale, psn, istart, eint;
  logic oq[$];
  int seed = 32'h3A331BCB;
  int failures = 0;
  int tests_run = 0;
  int power_control_register_m = 0;
  int dbl_m = 0;
  int md = 0;
  initial forever #20 CLK = ~CLK;
  pscc_ctrl #(.WAKE_CLKS(HC)) dut (.CLK(CLK), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .INT_START(istart), .INT_LEVEL_EN(lvl),
    .PROG_DOUBLE_SET(pset), .PROG_DOUBLE_VAL(pval), .EXT_ACCESS_SEL_N(easn),
    .EXT_INT_N(eint), .OSC_IN(osc), .RUN_ENABLE(run), .CLK_GATE_EN(gate),
    .OSC_RESTART(rosc), .WAKE_VECTOR(wvec), .MCYCLE_STROBE(mcyc), .OSC_OUT(oscout),
    .ALE(ale), .PROG_STORE_STROBE_N(psn));
  pscc_far_model #(.HOLD(HC)) far (.clk(CLK), .go_irq(girq), .go_pin(gpin),
    .int_start(istart), .ext_int_n(eint));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge CLK)
  begin
    if (ck)
      chk(oscout, oq[0]);
    oq.push_front(osc);
    osc <= 1'($random(seed));
  end
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge CLK);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge CLK);
    wr <= 1'b0;
    if (a == 2'h0 && md == 0)
    begin
      power_control_register_m = d;
      md = d[1] ? 2 : d[0];
    end
    repeat (2) @(posedge CLK);
    #1;
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge CLK);
    addr <= a;
    rd <= 1'b1;
    @(posedge CLK);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic strobe(input int w);
    @(posedge CLK);
    girq <= (w == 0);
    gpin <= (w == 1);
    pset <= (w == 2);
    @(posedge CLK);
    {girq, gpin, pset} <= 3'h0;
  endtask
  task automatic cmode;
    chk({run, gate, ale, psn}, md == 0 ? 8'h0F : (md == 1 ? 8'h07 : 8'h00));
  endtask
  task automatic mper;
    int n;
    int k;
    n = 0;
    k = 0;
    repeat (14) @(posedge CLK);
    ck = 1'b1;
    for (int i = 0; i < 40 && k < 2; i++)
    begin
      @(posedge CLK);
      #1;
      n = (mcyc === 1'b1 && k == 0) ? 0 : n + 1;
      k = k + (mcyc === 1'b1);
    end
    ck = 1'b0;
    if (k < 2)
    begin
      failures++;
    end
    else
    begin
      chk(8'(n), (dbl_m == 1 && easn) ? 8'h06 : 8'h0C);
    end
  endtask
  initial
  begin
    int k2;
    repeat (20) @(posedge CLK);
    rstn <= 1'b1;
    @(posedge CLK);
    #1;
    cmode;
    rreg(2'h0, 8'(power_control_register_m));
    rreg(2'h3, 8'h00);
    rreg(2'h1, 8'(1 - dbl_m));
    mper;
    wreg(2'h0, 8'h01);
    cmode;
    rreg(2'h0, 8'(power_control_register_m));
    strobe(0);
    power_control_register_m = 0;
    md = 0;
    repeat (3) @(posedge CLK);
    #1;
    cmode;
    rreg(2'h0, 8'(power_control_register_m));
    wreg(2'h0, 8'h02);
    cmode;
    wreg(2'h0, 8'h01);
    strobe(1);
    repeat (HC + 4) @(posedge CLK);
    #1;
    cmode;
    rreg(2'h0, 8'(power_control_register_m));
    @(posedge CLK);
    lvl <= 1'b1;
    strobe(1);
    repeat (3) @(posedge CLK);
    #1;
    chk(rosc, 1'b1);
    k2 = 0;
    for (int i = 0; i < HC + 20; i++)
    begin
      @(posedge CLK);
      #1;
      k2 += (wvec === 1'b1);
    end
    chk(8'(k2), 8'h01);
    power_control_register_m = 0;
    md = 0;
    cmode;
    rreg(2'h0, 8'(power_control_register_m));
    wreg(2'h0, 8'h03);
    cmode;
    @(posedge CLK);
    rstn <= 1'b0;
    repeat (2) @(posedge CLK);
    rstn <= 1'b1;
    power_control_register_m = 0;
    md = 0;
    @(posedge CLK);
    #1;
    cmode;
    wreg(2'h1, 8'($random(seed)));
    rreg(2'h1, 8'(1 - dbl_m));
    @(posedge CLK);
    pval <= 1'b1;
    strobe(2);
    dbl_m = 1;
    rreg(2'h1, 8'(1 - dbl_m));
    mper;
    @(posedge CLK);
    easn <= 1'b0;
    mper;
    stop_test;
  end
endmodule
